// File: rtl/aorp_consts.svh
/*
 * Constants of the converter result output port: pin positions on the shared data bus,
 * synchroniser bit positions, reset values and timing counts.
 * Assumes it is included by bare name from the package and the design modules.
 */
`ifndef AORP_CONSTS_SVH
`define AORP_CONSTS_SVH

// ==========================================================================
// timing
`define AORP_CLK_PERIOD_NS 100
`define AORP_CONV_TIME_NS 1000
`define AORP_CONV_CYCLES ((`AORP_CONV_TIME_NS + `AORP_CLK_PERIOD_NS - 1) / `AORP_CLK_PERIOD_NS)
`define AORP_MASTER_PHASES 4
`define AORP_WORD_BITS 16
`define AORP_CHAIN_EDGES 16

// ==========================================================================
// shared pin positions on the data bus
`define AORP_PIN_SDATA 8
`define AORP_PIN_SCLK 9
`define AORP_PIN_FRAME 10
`define AORP_PIN_OVERRUN 11
`define AORP_PIN_HIGH_LO 12

// ==========================================================================
// positions in the pin synchroniser vector
`define AORP_SY_CNV 0
`define AORP_SY_CS 1
`define AORP_SY_RD 2
`define AORP_SY_SER 3
`define AORP_SY_CLKSRC 4
`define AORP_SY_INV 5
`define AORP_SY_FPOL 6
`define AORP_SY_CODE 7
`define AORP_SY_RDT 8
`define AORP_SY_WIDTH 9

// ==========================================================================
// reset values
`define AORP_WORD_RESET 16'h0000
`define AORP_SYNC_RESET 9'h007

`endif

// File: rtl/aorp_link_if.sv
/*
 * Carrier between the core (system clock) and the slave serial link (host clock).
 * Assumes heldWord only changes when a conversion completes.
 */
`timescale 1ns/100ps
`default_nettype none

interface aorp_link_if;
    logic [15:0] heldWord; // stable result register, quasi-static across domains
    logic readActive; // link flop: a slave read is part way through
    logic slaveData; // serial data as the link shifts it

    modport core (output heldWord, input readActive, input slaveData);
    modport link (input heldWord, output readActive, output slaveData);
endinterface

`default_nettype wire

// File: rtl/aorp_output_port.sv
/*
 * Result output port of a 16-bit sampling converter: conversion sequencing, busy,
 * result register with output coding, parallel bus, serial master and slave port,
 * read overrun flag.
 * Assumes sampleCode comes from the analog core on sys_clk, offset binary, and is
 * valid when the conversion time has elapsed. The shared pins are modelled as
 * out / output-enable pairs (enable active low); pin 9 as an input arrives on
 * serialBitClockIn. Straps on pins 0..7 arrive as the separate mode inputs.
 */
// Operation
// - parallel mode drives bits 0-11 on pins
// - bits 12-15 parallel, high-Z in serial
// - serial result shifted out msb first
// - coding pin selects offset binary or twos complement
// - master data stable at both clock edges
// - slave, no invert: update on rising edge
// - slave, invert: update on falling edge
// - clock pin output in master, input slave
// - master frame marker active during data, polarity
// - slave read unfinished at completion: pulse overrun
// - busy from start until result latched
// - output bus on only with select and read
// - slave clock ignored unless chip select low
// - reset clears logic, aborts conversion
// - serial result held in on-chip register
// - clock source pin selects master or slave
// - master read during or after conversion
// - slave chain input appears after 16 clocks
// - convert start falling edge starts conversion
`include "aorp_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module aorp_output_port
    import aorp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic serialBitClockIn,
    input wire logic convertStartN,
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic interfaceSelect,
    input wire logic clockSourceSelect,
    input wire logic clockInvert,
    input wire logic frameMarkerPolarity,
    input wire logic outputCodingSelect,
    input wire logic readTimingOrChainIn,
    input wire logic [15:0] sampleCode,
    output logic busy,
    output logic [15:0] dataPinOut,
    output logic [15:0] dataPinOeN
);

    // ======================================================================
    // functions

    // core delivers offset binary; twos complement only flips the msb
    function automatic aorp_word_type encodeWord(input aorp_word_type raw, input logic offBin);
        encodeWord = offBin ? raw : {~raw[15], raw[14:0]};
    endfunction

    // ======================================================================
    // pin synchronisers
    logic [`AORP_SY_WIDTH-1:0] pinRaw;
    logic [`AORP_SY_WIDTH-1:0] pinMeta;
    logic [`AORP_SY_WIDTH-1:0] pinSync;
    logic cnvPrev;

    assign pinRaw = {readTimingOrChainIn, outputCodingSelect, frameMarkerPolarity,
                     clockInvert, clockSourceSelect, interfaceSelect, readStrobeN,
                     chipSelectN, convertStartN};

    // every pin passes two flops; only the second is read by logic
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pinMeta <= `AORP_SYNC_RESET;
            pinSync <= `AORP_SYNC_RESET;
            cnvPrev <= 1'b1;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            cnvPrev <= pinSync[`AORP_SY_CNV];
        end
    end

    // ======================================================================
    // decoded modes
    logic serialMode;
    logic masterMode;
    logic slaveMode;
    logic busEnable;
    logic invertSync;
    logic offsetBinary;
    logic readDuring;
    logic startEdge;

    assign serialMode = pinSync[`AORP_SY_SER];
    assign masterMode = serialMode & ~pinSync[`AORP_SY_CLKSRC];
    assign slaveMode = serialMode & pinSync[`AORP_SY_CLKSRC];
    // bus drives only while both select and read are held low
    assign busEnable = ~pinSync[`AORP_SY_CS] & ~pinSync[`AORP_SY_RD];
    assign invertSync = pinSync[`AORP_SY_INV];
    assign offsetBinary = pinSync[`AORP_SY_CODE];
    assign readDuring = pinSync[`AORP_SY_RDT];
    assign startEdge = cnvPrev & ~pinSync[`AORP_SY_CNV];

    // ======================================================================
    // conversion sequencer
    aorp_conv_type convState;
    aorp_conv_type next_convState;
    logic [7:0] convCount;
    logic [7:0] next_convCount;
    logic convDone;
    aorp_word_type newWord;
    aorp_word_type heldWord;

    assign newWord = encodeWord(sampleCode, offsetBinary);

    // start edges that arrive mid-conversion are ignored
    always_comb begin
        next_convState = convState;
        next_convCount = convCount;
        convDone = 1'b0;
        case (convState)
            CONV_IDLE: begin
                if (startEdge) begin
                    next_convState = CONV_RUN;
                    next_convCount = 8'(`AORP_CONV_CYCLES - 1);
                end
            end
            CONV_RUN: begin
                if (convCount == 8'h00) begin
                    next_convState = CONV_IDLE;
                    convDone = 1'b1;
                end else begin
                    next_convCount = convCount - 8'h01;
                end
            end
            default: begin
                next_convState = CONV_IDLE;
            end
        endcase
    end

    // reset aborts a conversion in flight; busy falls with the latch edge
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            convState <= CONV_IDLE;
            convCount <= 8'h00;
            busy <= 1'b0;
            heldWord <= `AORP_WORD_RESET;
        end else begin
            convState <= next_convState;
            convCount <= next_convCount;
            busy <= (next_convState == CONV_RUN);
            if (convDone) begin
                heldWord <= newWord;
            end
        end
    end

    // ======================================================================
    // slave link and its crossing
    aorp_link_if linkBus ();
    logic activeMeta;
    logic activeSync;
    logic overrunPulse;

    assign linkBus.heldWord = heldWord;

    aorp_serial_link linkSide (
        .reset(reset),
        .serialBitClockIn(serialBitClockIn),
        .clockInvert(clockInvert),
        .chipSelectN(chipSelectN),
        .chainIn(readTimingOrChainIn),
        .lnk(linkBus.link)
    );

    // read-active level crosses by two flops; a new result leaves the word already copied into the shifter unchanged
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            activeMeta <= 1'b0;
            activeSync <= 1'b0;
            overrunPulse <= 1'b0;
        end else begin
            activeMeta <= linkBus.readActive;
            activeSync <= activeMeta;
            overrunPulse <= convDone & slaveMode & activeSync;
        end
    end

    // ======================================================================
    // master serializer: four system cycles per bit, clock high in phases 1 and 2
    aorp_mser_type mserState;
    aorp_mser_type next_mserState;
    logic [3:0] bitIdx;
    logic [3:0] next_bitIdx;
    logic [1:0] phase;
    logic [1:0] next_phase;
    aorp_word_type shiftWord;
    aorp_word_type next_shiftWord;
    logic sclkLevel;
    logic frameActive;
    logic masterStart;
    aorp_word_type startWord;

    // read during conversion sends the previous word, otherwise the fresh one
    assign masterStart = masterMode & (readDuring ? startEdge : convDone);
    assign startWord = readDuring ? heldWord : newWord;

    always_comb begin
        next_mserState = mserState;
        next_bitIdx = bitIdx;
        next_phase = phase;
        next_shiftWord = shiftWord;
        case (mserState)
            MSER_IDLE: begin
                if (masterStart) begin
                    next_mserState = MSER_SHIFT;
                    next_bitIdx = 4'h0;
                    next_phase = 2'h0;
                    next_shiftWord = startWord;
                end
            end
            MSER_SHIFT: begin
                next_phase = phase + 2'h1;
                if (phase == 2'(`AORP_MASTER_PHASES - 1)) begin
                    // data moves only at the bit boundary, a cycle clear of both edges
                    next_shiftWord = {shiftWord[14:0], 1'b0};
                    if (bitIdx == 4'(`AORP_WORD_BITS - 1)) begin
                        next_mserState = MSER_IDLE;
                    end else begin
                        next_bitIdx = bitIdx + 4'h1;
                    end
                end
            end
            default: begin
                next_mserState = MSER_IDLE;
            end
        endcase
    end

    // clock and frame are registered so the pins carry no decode glitches
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mserState <= MSER_IDLE;
            bitIdx <= 4'h0;
            phase <= 2'h0;
            shiftWord <= `AORP_WORD_RESET;
            sclkLevel <= 1'b0;
            frameActive <= 1'b0;
        end else begin
            mserState <= next_mserState;
            bitIdx <= next_bitIdx;
            phase <= next_phase;
            shiftWord <= next_shiftWord;
            sclkLevel <= (next_mserState == MSER_SHIFT) & (next_phase[0] ^ next_phase[1]);
            frameActive <= (next_mserState == MSER_SHIFT);
        end
    end

    // ======================================================================
    // pin selection
    logic serialDataPin;
    logic sclkPin;
    logic framePin;
    logic [15:0] pinValue;
    logic [15:0] pinDrive;

    assign serialDataPin = slaveMode ? linkBus.slaveData : shiftWord[15];
    // clock invert acts in master mode as well
    assign sclkPin = sclkLevel ^ invertSync;
    // marker is active high with polarity low, active low with polarity high
    assign framePin = frameActive ^ pinSync[`AORP_SY_FPOL];

    // serial mode repurposes pins 8..11; pins 0..7 carry straps, 12..15 float
    assign pinValue = serialMode
        ? {4'h0, overrunPulse, framePin, sclkPin, serialDataPin, 8'h00}
        : heldWord;
    assign pinDrive = serialMode
        ? {4'h0, slaveMode, masterMode, masterMode, 1'b1, 8'h00}
        : 16'hffff;

    assign dataPinOut = pinValue;
    // enable low drives; anything not enabled, or a released bus, floats
    assign dataPinOeN = ~(pinDrive & {16{busEnable}});

endmodule

`default_nettype wire

// File: rtl/aorp_pkg.sv
/*
 * Types of the converter result output port.
 * Assumes the constants header is on the include path.
 */
package aorp_pkg;
    `include "aorp_consts.svh"

    // ======================================================================
    // state machines
    typedef enum logic [0:0] {
        CONV_IDLE = 1'b0,
        CONV_RUN = 1'b1
    } aorp_conv_type;

    typedef enum logic [0:0] {
        MSER_IDLE = 1'b0,
        MSER_SHIFT = 1'b1
    } aorp_mser_type;

    typedef logic [`AORP_WORD_BITS-1:0] aorp_word_type;
endpackage

// File: rtl/aorp_serial_link.sv
/*
 * Slave serial shifter running on the host's serial clock.
 * Assumes chip select and the chain input are launched by the host in step with its
 * own serial clock, so they are same-domain signals here and are sampled directly.
 */
`include "aorp_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module aorp_serial_link
    import aorp_pkg::*;
(
    input wire logic reset,
    input wire logic serialBitClockIn,
    input wire logic clockInvert,
    input wire logic chipSelectN,
    input wire logic chainIn,
    aorp_link_if.link lnk
);

    // ======================================================================
    // clock selection and gating
    logic shiftClk;
    logic frameClear;
    logic [4:0] edgeCount;
    logic [4:0] next_edgeCount;
    aorp_word_type shiftReg;

    // invert picks the updating edge; clock_invert is a strap, not changed in a frame
    assign shiftClk = serialBitClockIn ^ clockInvert;
    // a high chip select holds the shifter clear, so stray clocks do nothing
    assign frameClear = reset | chipSelectN;
    assign next_edgeCount = (edgeCount == 5'(`AORP_CHAIN_EDGES)) ? edgeCount : edgeCount + 5'h01;

    // ======================================================================
    // shift register: msb first, chain input fills from the bottom
    always_ff @(posedge shiftClk or posedge frameClear) begin
        if (frameClear) begin
            shiftReg <= `AORP_WORD_RESET;
            edgeCount <= 5'h00;
            lnk.readActive <= 1'b0;
        end else begin
            if (edgeCount == 5'h00) begin
                shiftReg <= {lnk.heldWord[14:0], chainIn};
            end else begin
                shiftReg <= {shiftReg[14:0], chainIn};
            end
            edgeCount <= next_edgeCount;
            // registered so the crossing into the core sees no glitch
            lnk.readActive <= (next_edgeCount != 5'(`AORP_CHAIN_EDGES));
        end
    end

    // msb is presented as soon as the frame opens, before the first edge
    assign lnk.slaveData = (edgeCount == 5'h00) ? lnk.heldWord[15] : shiftReg[15];

endmodule

`default_nettype wire

// File: verification/aorp_host_model.sv
/* host reading the slave serial port with its own 12 ns bit clock.
   assumes sdo is the resolved data pin and the read strobe is held low. */
`timescale 1ns/100ps
`default_nettype none
module aorp_host_model (
    input wire logic go,
    input wire logic [4:0] nBits,
    input wire logic glitch,
    input wire logic clkInv,
    input wire logic keep,
    input wire logic sdo,
    output logic csN,
    output logic sclk,
    output logic [16:0] got,
    output logic done
);
    // ======================================
    // one read per rising go; clock stands still between reads
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        got = 17'h00000;
        done = 1'b0;
        forever begin
            @(posedge go);
            done = 1'b0;
            sclk = ~clkInv; // idle so the first edge is a sampling edge
            // stray pulses while deselected
            if (glitch) repeat (3) begin
                #6 sclk = ~sclk;
                #6 sclk = ~sclk;
            end
            #5 csN = 1'b0;
            #500; // device enables its pin through a sync, so wait
            repeat (nBits) begin
                got = {got[15:0], sdo};
                sclk = ~sclk;
                #6 sclk = ~sclk;
                #6;
            end
            wait (!keep);
            csN = 1'b1;
            done = 1'b1;
        end
    end
endmodule
`default_nettype wire

// File: verification/aorp_output_port_bench.sv
/* bench for the result port: parallel, master and slave serial reads.
   assumes the host model owns the slave clock and its chip select. */
`include "aorp_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module aorp_output_port_bench;
    logic sys_clk, reset = 1'b1, convertStartN = 1'b1, benchCsN = 1'b1, readStrobeN = 1'b1;
    logic interfaceSelect = 1'b0, clockSourceSelect = 1'b0, clockInvert = 1'b0;
    logic frameMarkerPolarity = 1'b0, outputCodingSelect = 1'b1, readTimingOrChainIn = 1'b0;
    logic [15:0] sampleCode = 16'h0000, mWord = 16'h0000, dataPinOut, dataPinOeN;
    logic go = 1'b0, glitch = 1'b0, keep = 1'b0, sawOvr = 1'b0, sckPrev = 1'b0;
    logic busy, hostCsN, sclk, hostDone;
    logic [4:0] nBits = 5'h00;
    logic [16:0] hostGot;
    int fails, n_checks, cyc;
    wire chipSelectN = benchCsN & hostCsN;
    wire sdo = dataPinOeN[8] ? 1'bz : dataPinOut[8];

    aorp_output_port i_dut (.sys_clk(sys_clk), .reset(reset), .serialBitClockIn(sclk),
        .convertStartN(convertStartN), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
        .interfaceSelect(interfaceSelect), .clockSourceSelect(clockSourceSelect),
        .clockInvert(clockInvert), .frameMarkerPolarity(frameMarkerPolarity),
        .outputCodingSelect(outputCodingSelect), .readTimingOrChainIn(readTimingOrChainIn),
        .sampleCode(sampleCode), .busy(busy), .dataPinOut(dataPinOut), .dataPinOeN(dataPinOeN));
    aorp_host_model i_host (.go(go), .nBits(nBits), .glitch(glitch), .clkInv(clockInvert),
        .keep(keep), .sdo(sdo), .csN(hostCsN), .sclk(sclk), .got(hostGot), .done(hostDone));

    // ======================================
    // clock, master capture, overrun watch, timeout
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        sckPrev <= dataPinOut[9] ^ clockInvert;
        if (!dataPinOeN[10] && (dataPinOut[10] ^ frameMarkerPolarity) && !sckPrev
            && (dataPinOut[9] ^ clockInvert)) mWord <= {mWord[14:0], dataPinOut[8]};
        if (interfaceSelect && clockSourceSelect && !dataPinOeN[11] && dataPinOut[11])
            sawOvr <= 1'b1;
        if (cyc == 5000) begin
            fails++;
            close_out();
        end
    end

    // ======================================
    // tasks
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // straps change only under reset, so the synchronisers never see them move
    task set_mode(input logic ser, src, inv, pol, code, rdt);
        @(posedge sys_clk);
        reset <= 1'b1;
        benchCsN <= 1'b1;
        readStrobeN <= 1'b1;
        interfaceSelect <= ser;
        clockSourceSelect <= src;
        clockInvert <= inv;
        frameMarkerPolarity <= pol;
        outputCodingSelect <= code;
        readTimingOrChainIn <= rdt;
        @(negedge sys_clk);
        check(busy, 1'b0);
        check(dataPinOeN, 16'hffff);
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask
    task start(input logic [15:0] code);
        @(posedge sys_clk);
        sampleCode <= code;
        convertStartN <= 1'b0;
        repeat (2) @(posedge sys_clk);
        convertStartN <= 1'b1;
    endtask
    task conv(input logic [15:0] code);
        int n;
        start(code);
        n = 0;
        while (busy !== 1'b1 && n < 10) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (busy === 1'b1 && n < 30) begin
            @(negedge sys_clk);
            n++;
        end
        check(n, `AORP_CONV_CYCLES);
    endtask
    task bus(input logic off);
        @(posedge sys_clk);
        benchCsN <= off;
        readStrobeN <= off;
        repeat (4) @(negedge sys_clk);
    endtask
    task s_read(input logic [4:0] nb, input logic gl, input logic kp);
        @(posedge sys_clk);
        nBits <= nb;
        glitch <= gl;
        keep <= kp;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask
    task wait_host;
        int n;
        n = 0;
        while (hostDone !== 1'b1 && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
    endtask

    // ======================================
    // scenarios
    initial begin
        // parallel reads, offset binary then two's complement
        for (int i = 0; i < 2; i++) begin
            set_mode(1'b0, 1'b0, 1'b0, 1'b0, ~i[0], 1'b0);
            conv(16'h8001);
            bus(1'b0);
            check(dataPinOeN, 16'h0000);
            check(dataPinOut, i[0] ? 16'h0001 : 16'h8001);
            bus(1'b1);
            check(dataPinOeN, 16'hffff);
        end
        start(16'h1234);
        repeat (6) @(posedge sys_clk);
        // master reads: after conversion, or previous word during it
        for (int i = 0; i < 4; i++) begin
            set_mode(1'b1, 1'b0, i[0], i[1], 1'b1, i[0] ^ i[1]);
            bus(1'b0);
            conv(16'ha5c3);
            repeat (80) @(posedge sys_clk);
            conv(16'h3c5a);
            repeat (80) @(posedge sys_clk);
            check(mWord, (i[0] ^ i[1]) ? 16'ha5c3 : 16'h3c5a);
            check(dataPinOeN[15:12], 4'hf);
        end
        // slave reads in both clock senses; chain level follows the word
        for (int i = 0; i < 2; i++) begin
            set_mode(1'b1, 1'b1, i[0], 1'b0, i[0], i[0]);
            readStrobeN <= 1'b0;
            conv(16'h9e17);
            s_read(5'h11, i[0], 1'b0);
            wait_host;
            check(hostGot, {i[0] ? 16'h9e17 : 16'h1e17, i[0]});
        end
        check(sawOvr, 1'b0);
        // a partial read still open when the next result lands
        s_read(5'h05, 1'b0, 1'b1);
        repeat (12) @(posedge sys_clk);
        conv(16'h7777);
        repeat (3) @(posedge sys_clk);
        check(sawOvr, 1'b1);
        keep <= 1'b0;
        wait_host;
        close_out();
    end
endmodule
`default_nettype wire

// File: verification/aorp_output_port_properties.sv
/* pin-level assertions for the result port, bound to the top module.
   assumes straps change only while reset is high. */
`timescale 1ns/100ps
`default_nettype none
module aorp_output_port_properties (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic serialBitClockIn,
    input wire logic convertStartN,
    input wire logic chipSelectN,
    input wire logic readStrobeN,
    input wire logic interfaceSelect,
    input wire logic clockSourceSelect,
    input wire logic clockInvert,
    input wire logic frameMarkerPolarity,
    input wire logic outputCodingSelect,
    input wire logic readTimingOrChainIn,
    input wire logic [15:0] sampleCode,
    input wire logic busy,
    input wire logic [15:0] dataPinOut,
    input wire logic [15:0] dataPinOeN
);
    // ======================================
    // helpers
    logic [3:0] offHist;
    logic [6:0] frameCnt;
    wire frameOn = interfaceSelect && !clockSourceSelect && !dataPinOeN[10]
        && (dataPinOut[10] ^ frameMarkerPolarity);
    wire sclkInt = dataPinOut[9] ^ clockInvert;

    // strobe history; four samples cover the two-stage sync lag
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            offHist <= 4'hf;
            frameCnt <= 7'h00;
        end else begin
            offHist <= {offHist[2:0], chipSelectN | readStrobeN};
            frameCnt <= frameOn ? frameCnt + 7'h01 : 7'h00;
        end
    end

    // ======================================
    // properties
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    a_busy_len: assert property ($rose(busy) |-> busy[*8] ##1 busy[*2] ##1 !busy)
        else $error("busy width wrong");
    a_start_busy: assert property ($fell(convertStartN) && !busy |-> ##[2:5] $rose(busy))
        else $error("start edge lost");
    a_bus_off: assert property (&offHist |-> &dataPinOeN)
        else $error("bus not released");
    a_bus_on: assert property (~|offHist && !interfaceSelect |-> dataPinOeN == 16'h0000)
        else $error("parallel bus not driven");
    a_top_hiz: assert property (interfaceSelect |-> &dataPinOeN[15:12])
        else $error("upper bits driven in serial");
    a_clk_dir: assert property (interfaceSelect && clockSourceSelect |-> &dataPinOeN[10:9])
        else $error("clock pin driven in slave");
    a_frame_len: assert property (frameCnt != 7'h00 && !frameOn |-> frameCnt == 7'h40)
        else $error("frame length wrong");
    a_data_still: assert property (frameOn && $changed(dataPinOut[8]) |-> !sclkInt && !$past(sclkInt))
        else $error("data moved near clock high");
    a_ovr_pulse: assert property (interfaceSelect && clockSourceSelect && !dataPinOeN[11] && dataPinOut[11]
        |-> (!busy && ($past(busy) || $past(busy, 2) || $past(busy, 3))) ##1 !dataPinOut[11])
        else $error("overrun pulse misplaced");
endmodule

bind aorp_output_port aorp_output_port_properties i_props (
    .sys_clk(sys_clk), .reset(reset), .serialBitClockIn(serialBitClockIn),
    .convertStartN(convertStartN), .chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
    .interfaceSelect(interfaceSelect), .clockSourceSelect(clockSourceSelect),
    .clockInvert(clockInvert), .frameMarkerPolarity(frameMarkerPolarity),
    .outputCodingSelect(outputCodingSelect), .readTimingOrChainIn(readTimingOrChainIn),
    .sampleCode(sampleCode), .busy(busy), .dataPinOut(dataPinOut), .dataPinOeN(dataPinOeN)
);
`default_nettype wire
